// ---- rtl/otc_consts.vh ----
// constants for the orientation trip configuration block
// assumes byte address = 4 * register index on a 32-bit APB
`ifndef OTC_CONSTS_VH
`define OTC_CONSTS_VH
`define OTC_IDX_STATUS      8'h10
`define OTC_IDX_CFG         8'h11
`define OTC_IDX_COUNT       8'h12
`define OTC_IDX_BF_Z        8'h13
`define OTC_IDX_THS         8'h14
`define OTC_IDX_MODE        8'h18
`define OTC_IDX_MASK        8'h19
`define OTC_IDX_STEP        8'h1A
`define OTC_RST_CFG         8'h80
`define OTC_RST_COUNT       8'h00
`define OTC_RST_BF_Z        8'h44
`define OTC_RST_THS         8'h84
`define OTC_RST_MODE        8'h00
`define OTC_RST_MASK        8'h00
`define OTC_CFG_CLR_BIT     7
`define OTC_CFG_EN_BIT      6
`define OTC_ST_CHG_BIT      7
`define OTC_ST_FREEZE_BIT   6
`define OTC_CLK_NS          100
`define OTC_QMS_NS          250000
`define OTC_OS_NORMAL       2'h0
`define OTC_OS_QUIET        2'h1
`define OTC_OS_FINE         2'h2
`define OTC_OS_ECON         2'h3
`endif

// ---- rtl/otc_orientation_trip_config.v ----
// orientation trip configuration, debounce and decision logic with APB registers
// assumes angle inputs and sample data are synchronous to pclk; one clock domain
//
// The APB register port was decided locally.
`include "otc_consts.vh"

// Behaviour
// R1: the debounce advances one time step per tick, step chosen from sample rate and oversampling.
// R2: the z lockout angle resets to 29 degrees and spans 14 to 42 degrees.
// R3: z lockout codes 0..7 select 14,18,21,25,29,33,37,42 degrees, reset code 100.
// R4: back/front code resets to 01 (75 degrees) and steps 5 degrees over 65 to 80.
// R5: code 00 gives back below 80 or above 280 and front within 100..260, each code narrowing 5.
// R6: the trip threshold is a five-bit code in bits 7..3 resetting to 1_0000 (45 degrees).
// R7: threshold codes map to approximate angles 15 through 75 degrees.
// R8: the margin code in bits 2..0 sets a 0..24 degree margin, reset 100 giving 14.
// R9: landscape to portrait trips at threshold plus margin, the reverse at threshold minus it.
// R10: software keeps threshold plus margin code between 0 and 32 and margin below threshold.
// R11: a new orientation commits only after the candidate held for count times the step.
// R12: clear mode zeroes the debounce when the candidate lapses, otherwise it decrements.
// R13: any wake/sleep transition resets the debounce counter.
// R14: the change flag sets on first detection after standby and on any change, cleared by read.
// R15: orientation is held while any axis exceeds 1.25 g.
module otc_orientation_trip_config #(
  parameter QMS_CYCLES = `OTC_QMS_NS / `OTC_CLK_NS
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clk_en,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         irq,
  input  wire        active,
  input  wire        sleep_state,
  input  wire        over_range,
  input  wire [7:0]  z_tilt_angle,
  input  wire [8:0]  z_angle,
  input  wire [7:0]  pl_angle,
  input  wire [1:0]  pl_dir,
  output reg  [7:0]  orientation_status
);

  reg  [7:0]  cfg_r;
  reg  [7:0]  count_r;
  reg  [7:0]  bf_z_r;
  reg  [7:0]  ths_r;
  reg  [7:0]  mode_r;
  reg  [7:0]  mask_r;
  reg         chg_r;
  reg         freeze_r;
  reg  [1:0]  lapo_r;
  reg         bafro_r;
  reg         first_r;
  reg         sleep_r;
  reg  [7:0]  dbc_r;
  reg  [9:0]  qms_cnt_r;
  reg  [19:0] tick_cnt_r;
  reg  [7:0]  dbc_nxt;
  reg         commit;
  reg         cand_freeze;
  reg  [1:0]  cand_lapo;
  reg         cand_bafro;
  reg  [8:0]  bf_off;
  reg  [7:0]  ths_ang;
  reg  [7:0]  margin_ang;
  wire [7:0]  idx;
  wire        acc;
  wire        rd_status;
  wire [9:0]  step_qms;
  wire        tick;
  wire        differs;
  wire        chg_nxt;

  // back/front window edges at code 00; each code step narrows both sides by BF_STEP
  localparam [8:0] BF_BACK_BELOW  = 9'h050;
  localparam [8:0] BF_BACK_ABOVE  = 9'h118;
  localparam [8:0] BF_FRONT_ABOVE = 9'h064;
  localparam [8:0] BF_FRONT_BELOW = 9'h104;
  localparam [8:0] BF_STEP        = 9'h005;

  // step length in quarter milliseconds
  function [9:0] step_of;
    input [2:0] rate;
    input [1:0] os;
    begin
      case (rate)
        3'h0:    step_of = 10'h005;
        3'h1:    step_of = 10'h00A;
        3'h2:    step_of = (os == `OTC_OS_FINE) ? 10'h00A : 10'h014;
        3'h3:    step_of = (os == `OTC_OS_FINE) ? 10'h00A : 10'h028;
        3'h4:    step_of = (os == `OTC_OS_FINE) ? 10'h00A : 10'h050;
        3'h5:    step_of = (os == `OTC_OS_FINE) ? 10'h00A :
                           (os == `OTC_OS_NORMAL) ? 10'h050 : 10'h140;
        default: step_of = (os == `OTC_OS_FINE) ? 10'h00A :
                           (os == `OTC_OS_NORMAL) ? 10'h050 :
                           (os == `OTC_OS_ECON) ? 10'h280 : 10'h140;
      endcase
    end
  endfunction

  // R3 lockout code to degrees
  function [7:0] lockout_ang;
    input [2:0] c;
    begin
      case (c)
        3'h0:    lockout_ang = 8'h0E;
        3'h1:    lockout_ang = 8'h12;
        3'h2:    lockout_ang = 8'h15;
        3'h3:    lockout_ang = 8'h19;
        3'h4:    lockout_ang = 8'h1D;
        3'h5:    lockout_ang = 8'h21;
        3'h6:    lockout_ang = 8'h25;
        default: lockout_ang = 8'h2A;
      endcase
    end
  endfunction

  // R7 codes between the listed points take the lower neighbour
  function [7:0] ths_of;
    input [4:0] c;
    begin
      if (c <= 5'h08)
        ths_of = 8'h0F;
      else if (c <= 5'h0B)
        ths_of = 8'h14;
      else if (c == 5'h0C)
        ths_of = 8'h1E;
      else if (c <= 5'h0E)
        ths_of = 8'h23;
      else if (c == 5'h0F)
        ths_of = 8'h28;
      else if (c <= 5'h12)
        ths_of = 8'h2D;
      else if (c == 5'h13)
        ths_of = 8'h37;
      else if (c <= 5'h16)
        ths_of = 8'h3C;
      else if (c <= 5'h18)
        ths_of = 8'h46;
      else
        ths_of = 8'h4B;
    end
  endfunction

  // R8 margin code to degrees
  function [7:0] margin_of;
    input [2:0] c;
    begin
      case (c)
        3'h0:    margin_of = 8'h00;
        3'h1:    margin_of = 8'h04;
        3'h2:    margin_of = 8'h07;
        3'h3:    margin_of = 8'h0B;
        3'h4:    margin_of = 8'h0E;
        3'h5:    margin_of = 8'h11;
        3'h6:    margin_of = 8'h15;
        default: margin_of = 8'h18;
      endcase
    end
  endfunction

  // status layout shared by the read path and the status output
  function [7:0] status_word;
    input       chg;
    input       frz;
    input [1:0] lapo;
    input       bafro;
    begin
      status_word = {chg, frz, 3'h0, lapo, bafro};
    end
  endfunction

  assign idx       = paddr[9:2];
  assign acc       = psel & penable & pready;
  assign rd_status = acc & ~pwrite & (idx == `OTC_IDX_STATUS);
  // R1 step from rate and oversampling
  assign step_qms  = step_of(mode_r[2:0], mode_r[4:3]);
  assign tick      = (tick_cnt_r == 20'h00000) && (qms_cnt_r == 10'h000);
  assign differs   = (cand_freeze != freeze_r) || (cand_lapo != lapo_r) ||
                     (cand_bafro != bafro_r);

  // candidate orientation from the live angles
  always @* begin
    bf_off      = {6'h00, bf_z_r[7:6]} * BF_STEP;
    ths_ang     = ths_of(ths_r[7:3]);
    margin_ang  = margin_of(ths_r[2:0]);
    // R2 lockout below the programmed tilt
    cand_freeze = (z_tilt_angle < lockout_ang(bf_z_r[2:0]));
    cand_bafro  = bafro_r;
    // R5 windows narrow with the code
    if ((z_angle < BF_BACK_BELOW - bf_off) || (z_angle > BF_BACK_ABOVE + bf_off))
      cand_bafro = 1'b1;
    else if ((z_angle > BF_FRONT_ABOVE + bf_off) && (z_angle < BF_FRONT_BELOW - bf_off))
      cand_bafro = 1'b0;
    // R9 hysteresis around the trip angle; wrap guarded by R10 on software
    cand_lapo = lapo_r;
    if (lapo_r[1] && ({1'b0, pl_angle} > {1'b0, ths_ang} + {1'b0, margin_ang}))
      cand_lapo = {1'b0, pl_dir[1]};
    else if (!lapo_r[1] && (pl_angle < ths_ang - margin_ang))
      cand_lapo = {1'b1, pl_dir[0]};
    else if (!lapo_r[1])
      cand_lapo = {1'b0, pl_dir[1]};
    else
      cand_lapo = {1'b1, pl_dir[0]};
  end

  // debounce next value and commit decision
  always @* begin
    dbc_nxt = dbc_r;
    commit  = 1'b0;
    if (sleep_state != sleep_r) begin
      // R13 wake/sleep change restarts debounce
      dbc_nxt = 8'h00;
    end else if (!active || !cfg_r[`OTC_CFG_EN_BIT]) begin
      dbc_nxt = 8'h00;
    end else if (tick) begin
      if (over_range) begin
        // R15 hold position above range
        dbc_nxt = dbc_r;
      end else if (differs || first_r) begin
        // R11 commit once the count is reached
        // count 0 commits on the first tick
        if (dbc_r >= count_r) begin
          commit  = 1'b1;
          dbc_nxt = 8'h00;
        end else begin
          dbc_nxt = dbc_r + 8'h01;
        end
      end else if (cfg_r[`OTC_CFG_CLR_BIT]) begin
        // R12 clear mode
        dbc_nxt = 8'h00;
      end else if (dbc_r != 8'h00) begin
        // R12 decrement mode
        dbc_nxt = dbc_r - 8'h01;
      end
    end
  end

  // R14 set wins over the read clear
  assign chg_nxt = (commit && (differs || first_r)) ? 1'b1 : (rd_status ? 1'b0 : chg_r);

  // step timer: quarter milliseconds, then steps
  // QMS_CYCLES has to fit the 20-bit prescaler
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qms_cnt_r  <= 10'h000;
      tick_cnt_r <= 20'h00000;
    end else if (clk_en) begin
      if (tick_cnt_r != 20'h00000) begin
        tick_cnt_r <= tick_cnt_r - 20'h00001;
      end else begin
        tick_cnt_r <= QMS_CYCLES[19:0] - 20'h00001;
        qms_cnt_r  <= (qms_cnt_r == 10'h000) ? step_qms - 10'h001 : qms_cnt_r - 10'h001;
      end
    end
  end

  // orientation state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbc_r   <= 8'h00;
      chg_r   <= 1'b0;
      freeze_r <= 1'b0;
      lapo_r  <= 2'h0;
      bafro_r <= 1'b0;
      first_r <= 1'b1;
      sleep_r <= 1'b0;
    end else if (clk_en) begin
      dbc_r   <= dbc_nxt;
      chg_r   <= chg_nxt;
      sleep_r <= sleep_state;
      if (!active)
        first_r <= 1'b1;
      else if (commit)
        first_r <= 1'b0;
      if (commit) begin
        freeze_r <= cand_freeze;
        lapo_r  <= cand_lapo;
        bafro_r <= cand_bafro;
      end
    end
  end

  // APB slave: one wait state, then the access completes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r   <= `OTC_RST_CFG;
      count_r <= `OTC_RST_COUNT;
      bf_z_r  <= `OTC_RST_BF_Z;
      ths_r   <= `OTC_RST_THS;
      mode_r  <= `OTC_RST_MODE;
      mask_r  <= `OTC_RST_MASK;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (clk_en) begin
      pready  <= psel & penable & ~pready;
      pslverr <= 1'b0;
      if (psel & penable & ~pready) begin
        prdata <= 32'h00000000;
        case (idx)
          `OTC_IDX_STATUS: prdata[7:0] <= status_word(chg_r, freeze_r, lapo_r, bafro_r);
          `OTC_IDX_CFG:    prdata[7:0] <= cfg_r;
          `OTC_IDX_COUNT:  prdata[7:0] <= count_r;
          `OTC_IDX_BF_Z:   prdata[7:0] <= bf_z_r;
          `OTC_IDX_THS:    prdata[7:0] <= ths_r;
          `OTC_IDX_MODE:   prdata[7:0] <= mode_r;
          `OTC_IDX_MASK:   prdata[7:0] <= mask_r;
          `OTC_IDX_STEP:   prdata[9:0] <= step_qms;
          default:         pslverr     <= 1'b1;
        endcase
      end
      if (acc & pwrite) begin
        case (idx)
          `OTC_IDX_CFG:   cfg_r   <= {pwdata[7:6], 6'h00};
          `OTC_IDX_COUNT: count_r <= pwdata[7:0];
          // R4 R2 reserved bits kept zero
          `OTC_IDX_BF_Z:  bf_z_r  <= {pwdata[7:6], 3'h0, pwdata[2:0]};
          // R6 R8 threshold and margin codes
          `OTC_IDX_THS:   ths_r   <= pwdata[7:0];
          `OTC_IDX_MODE:  mode_r  <= {3'h0, pwdata[4:0]};
          `OTC_IDX_MASK:  mask_r  <= {pwdata[7], 7'h00};
          default:        cfg_r   <= cfg_r;
        endcase
      end
    end
  end

  // registered outputs; irq follows the sticky flag under its mask
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq                <= 1'b0;
      orientation_status <= 8'h00;
    end else if (clk_en) begin
      irq                <= chg_nxt & mask_r[`OTC_ST_CHG_BIT];
      orientation_status <= status_word(chg_nxt, commit ? cand_freeze : freeze_r,
                                        commit ? cand_lapo : lapo_r,
                                        commit ? cand_bafro : bafro_r);
    end
  end

endmodule // otc_orientation_trip_config

// ---- bench/otc_trip_asserts.sv ----
// checker for the orientation trip block: bus timing and status shape
// assumes one pclk domain and presetn asynchronous, active low
module otc_trip_asserts (
  input logic        pclk,
  input logic        presetn,
  input logic        clk_en,
  input logic        psel,
  input logic        penable,
  input logic [31:0] paddr,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        irq,
  input logic [7:0]  orientation_status
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  pready_wait_a: assert property (psel && penable && !pready && clk_en |=> pready)
    else $error("pready did not follow the access phase");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready stood longer than one cycle");
  pready_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  err_unmapped_a: assert property (pready && paddr[9:2] == 8'h00 |-> pslverr)
    else $error("unmapped index not refused");
  err_mapped_a: assert property (pready && paddr[9:2] == 8'h13 |-> !pslverr)
    else $error("mapped index refused");
  rdata_hold_a: assert property (!pready |-> $stable(prdata))
    else $error("read data moved between accesses");
  rdata_width_a: assert property (prdata[31:10] == 22'h000000)
    else $error("read data above the step width");
  rdata_byte_a: assert property (pready && paddr[9:2] != 8'h1A |-> prdata[31:8] == 24'h000000)
    else $error("read data above the register width");
  status_resv_a: assert property (orientation_status[5:3] == 3'h0)
    else $error("reserved status bits set");
  reset_quiet_a: assert property ($rose(presetn) |-> !irq && orientation_status == 8'h00)
    else $error("outputs not quiet after reset");
  irq_flag_a: assert property (!orientation_status[7] && !$past(orientation_status[7]) |-> !irq)
    else $error("interrupt without change flag");
endmodule // otc_trip_asserts

bind otc_orientation_trip_config otc_trip_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
  .orientation_status(orientation_status));

// ---- bench/tb.sv ----
// self-checking bench for the orientation trip block
// assumes one wait state on APB and a shortened quarter-millisecond count
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic w; logic [7:0] i; logic [7:0] d; logic [7:0] e; logic r;} otc_row_t;
  logic        pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic        active = 0, sleep_state = 0, over_range = 0, pready, pslverr, irq, er;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  logic [7:0]  z_tilt_angle = 8'h5A, pl_angle = 8'h5A, orientation_status;
  logic [8:0]  z_angle = 9'h0B4;
  logic [1:0]  pl_dir = 2'h0;
  integer      bad_count = 0, n_checks = 0;
  otc_row_t    rows [0:24] = '{
    '{0,8'h13,8'h00,8'h44,0}, '{0,8'h14,8'h00,8'h84,0}, '{0,8'h11,8'h00,8'h80,0},
    '{0,8'h12,8'h00,8'h00,0}, '{0,8'h19,8'h00,8'h00,0}, '{0,8'h00,8'h00,8'h00,1},
    '{1,8'h00,8'h5A,8'h00,1}, '{1,8'h13,8'hC7,8'h00,0}, '{0,8'h13,8'h00,8'hC7,0},
    '{1,8'h13,8'h44,8'h00,0}, '{1,8'h14,8'hCA,8'h00,0}, '{0,8'h14,8'h00,8'hCA,0}, // sum 27
    '{1,8'h14,8'h84,8'h00,0}, '{1,8'h18,8'h1C,8'h00,0}, '{0,8'h1A,8'h00,8'h50,0},
    '{1,8'h18,8'h0B,8'h00,0}, '{0,8'h1A,8'h00,8'h28,0}, '{1,8'h18,8'h12,8'h00,0},
    '{0,8'h1A,8'h00,8'h0A,0}, '{1,8'h18,8'h02,8'h00,0}, '{0,8'h1A,8'h00,8'h14,0},
    '{1,8'h18,8'h01,8'h00,0}, '{0,8'h1A,8'h00,8'h0A,0}, '{1,8'h18,8'h00,8'h00,0},
    '{0,8'h1A,8'h00,8'h05,0}};

  otc_orientation_trip_config #(.QMS_CYCLES(2)) dut (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .active(active), .sleep_state(sleep_state),
    .over_range(over_range), .z_tilt_angle(z_tilt_angle), .z_angle(z_angle),
    .pl_angle(pl_angle), .pl_dir(pl_dir), .orientation_status(orientation_status));

  initial begin
    forever #50 pclk = ~pclk;
  end

  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one transfer, entered just after a rising edge; idle edge after release
  task apb(input logic w, input logic [7:0] i, input logic [7:0] d,
           output logic [31:0] q, output logic e);
    integer k;
    k = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= {22'h0, i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    if (k >= 50) begin
      bad_count++;
      wrap_up;
    end
    @(posedge pclk);
  endtask

  // hold: status must still show the value after 200 cycles; else it must reach it
  task st(input logic [7:0] m, input logic [7:0] v, input logic hold);
    integer k;
    k = 0;
    if (hold) repeat (200) @(posedge pclk);
    else while ((orientation_status & m) !== v && k < 400) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 400) begin
      bad_count++;
      wrap_up;
    end
    chk(orientation_status & m, v);
  endtask

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    foreach (rows[n]) begin
      apb(rows[n].w, rows[n].i, rows[n].d, rd, er);
      chk(er, rows[n].r);
      if (!rows[n].w && !rows[n].r) chk(rd, rows[n].e);
    end
    apb(1, 8'h11, 8'hC0, rd, er);
    apb(1, 8'h19, 8'h80, rd, er);
    active <= 1;
    st(8'hFF, 8'h80, 0);
    chk(irq, 1);
    apb(0, 8'h10, 8'h00, rd, er);
    chk(rd, 8'h80);
    repeat (3) @(posedge pclk);
    chk({irq, orientation_status[7]}, 2'b00);
    pl_angle <= 8'd40;
    st(8'h06, 8'h00, 1);
    pl_angle <= 8'd20;
    st(8'h06, 8'h04, 0);
    pl_angle <= 8'd50;
    st(8'h06, 8'h04, 1);
    pl_angle <= 8'd70;
    st(8'h06, 8'h00, 0);
    over_range <= 1;
    z_angle <= 9'd0;
    st(8'h01, 8'h00, 1);
    over_range <= 0;
    st(8'h01, 8'h01, 0);
    z_angle <= 9'd104;
    st(8'h01, 8'h01, 1);
    z_angle <= 9'd106;
    st(8'h01, 8'h00, 0);
    z_tilt_angle <= 8'd30;
    st(8'h40, 8'h00, 1);
    z_tilt_angle <= 8'd28;
    st(8'h40, 8'h40, 0);
    apb(1, 8'h13, 8'h47, rd, er);
    z_tilt_angle <= 8'd40;
    st(8'h40, 8'h40, 1);
    apb(1, 8'h12, 8'h03, rd, er);
    apb(1, 8'h11, 8'h40, rd, er);
    z_tilt_angle <= 8'd45;
    st(8'h40, 8'h00, 0);
    // now one cycle after a commit tick: ticks fall 9, 19, 29 ... cycles on
    pl_angle <= 8'd20;
    repeat (20) @(posedge pclk);
    chk(orientation_status & 8'h06, 8'h00);
    pl_angle <= 8'd40;
    repeat (10) @(posedge pclk);
    pl_angle <= 8'd20;
    repeat (32) @(posedge pclk);
    chk(orientation_status & 8'h06, 8'h04);
    pl_angle <= 8'd70;
    repeat (18) @(posedge pclk);
    sleep_state <= 1;
    repeat (25) @(posedge pclk);
    chk(orientation_status & 8'h06, 8'h04);
    st(8'h06, 8'h00, 0);
    clk_en <= 0;
    pl_angle <= 8'd20;
    repeat (60) @(posedge pclk);
    chk(orientation_status & 8'h06, 8'h00);
    clk_en <= 1;
    st(8'h06, 8'h04, 0);
    presetn <= 0;
    @(posedge pclk);
    @(posedge pclk);
    chk({irq, orientation_status}, 9'h000);
    presetn <= 1;
    @(posedge pclk);
    apb(0, 8'h13, 8'h00, rd, er);
    chk(rd, 8'h44);
    apb(1, 8'h18, 8'h1E, rd, er);
    apb(0, 8'h1A, 8'h00, rd, er);
    chk(rd, 32'h280);
    wrap_up;
  end
endmodule // tb
